// ==== tb.sv ====
/*
 * Self-checking bench of the waveform address generator.
 * Assumes wag_engine with its bound checker and the DAC model.
 */
`timescale 1ns/1ps
module tb;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  host_addr = 4'h0;
	logic [7:0]  host_wdata = 8'h00;
	logic        host_wr = 1'b0;
	logic        host_rd = 1'b0;
	logic        ext_trigger = 1'b0;
	wire  [7:0]  host_rdata;
	wire  [11:0] dac_data;
	wire         dac_sample_clock;
	wire         sync_out;
	wire         marker_out;
	int          n_fail = 0;
	int          num_checks = 0;
	int          cyc = 0;
	logic [7:0]  rv;

	always #10 clock = ~clock;

	wag_engine #(.DIV_MAX(15)) uut (
		.waveform_clock   (clock),
		.rst_n            (rst_n),
		.host_addr        (host_addr),
		.host_wdata       (host_wdata),
		.host_wr          (host_wr),
		.host_rd          (host_rd),
		.host_rdata       (host_rdata),
		.ext_trigger      (ext_trigger),
		.dac_data         (dac_data),
		.dac_sample_clock (dac_sample_clock),
		.sync_out         (sync_out),
		.marker_out       (marker_out)
	);
	wag_dac_model u_dac (
		.dac_sample_clock (dac_sample_clock),
		.dac_data         (dac_data),
		.sync_out         (sync_out),
		.marker_out       (marker_out)
	);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish;
		end
	end
	task automatic chk(input string what, input logic [11:0] exp,
			input logic [11:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge clock);
		host_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge clock);
		host_rd <= 1'b0;
		#1;
		rv = host_rdata;
	endtask
	task automatic clr;
		u_dac.samp.delete();
		u_dac.flag.delete();
		u_dac.mark.delete();
		u_dac.gap.delete();
	endtask
	task automatic take(input int n);
		int k;
		for (k = 0; k < 400 && u_dac.samp.size() < n; k++)
			@(posedge clock);
		chk("sample count", n, u_dac.samp.size());
	endtask
	function automatic logic [11:0] nx(input logic [11:0] s);
		case (s)
			12'h000: nx = 12'h001;
			12'h001: nx = 12'h008;
			12'h008: nx = 12'h009;
			default: nx = 12'h000;
		endcase
	endfunction
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_dds;
		int i;
		wr(4'hC, 8'h00);
		wr(4'hD, 8'h00);
		for (i = 0; i < 4096; i++) begin
			wr(4'hE, i[7:0]);
			wr(4'hF, {4'h0, i[11:8]});
		end
		for (i = 0; i < 3; i++)
			wr(i[3:0], 8'h00);
		wr(4'h3, 8'h0C);
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h02);
		clr;
		take(6);
		for (i = 0; i < 5; i++) begin
			chk("dds step", 12'd6,
				u_dac.samp[i+1] - u_dac.samp[i]);
			chk("dds gap", 12'd2, u_dac.gap[i+1]);
		end
		wr(4'h3, 8'h14);
		wr(4'h4, 8'h00);
		// drain samples whose spacing still holds the old increment
		repeat (2) @(posedge clock);
		clr;
		take(6);
		for (i = 0; i < 5; i++)
			chk("sweep step", 12'd10,
				u_dac.samp[i+1] - u_dac.samp[i]);
		wr(4'h5, 8'h00);
		$display("test dds done");
	endtask
	task automatic t_synth;
		int i;
		wr(4'hA, 8'h43);
		wr(4'hB, 8'h03);
		wr(4'hB, 8'h00);
		wr(4'hB, 8'h02);
		wr(4'hB, 8'h00);
		wr(4'h6, 8'h02);
		for (i = 7; i < 10; i++)
			wr(i[3:0], 8'h00);
		wr(4'h5, 8'h03);
		clr;
		take(8);
		for (i = 0; i < 7; i++) begin
			chk("synth next", (u_dac.samp[i] + 12'd1) & 12'h3,
				u_dac.samp[i+1]);
			chk("synth gap", 12'd3, u_dac.gap[i+1]);
			chk("sync", {11'h0, u_dac.samp[i] == 12'h0},
				{11'h0, u_dac.flag[i]});
			chk("marker", {11'h0, u_dac.samp[i] == 12'h2},
				{11'h0, u_dac.mark[i]});
		end
		// stop first so playback restarts inside the short length
		wr(4'h5, 8'h00);
		wr(4'h5, 8'h43);
		clr;
		take(6);
		for (i = 0; i < 5; i++)
			chk("square", u_dac.samp[i] ^ 12'h1, u_dac.samp[i+1]);
		wr(4'h5, 8'h00);
		$display("test synth done");
	endtask
	task automatic t_burst;
		wr(4'hA, 8'h40);
		wr(4'hB, 8'h02);
		wr(4'hB, 8'h00);
		wr(4'hB, 8'h00);
		clr;
		wr(4'h5, 8'h0B);
		repeat (20) @(posedge clock);
		rd(4'hE);
		chk("wait state", 12'd1, rv[1:0]);
		chk("idle ticks", 12'd0, u_dac.samp.size());
		wr(4'h5, 8'h8B);
		repeat (60) @(posedge clock);
		chk("burst soft", 12'd8, u_dac.samp.size());
		clr;
		wr(4'h5, 8'h0F);
		@(posedge clock);
		ext_trigger <= 1'b1;
		repeat (4) @(posedge clock);
		ext_trigger <= 1'b0;
		repeat (60) @(posedge clock);
		chk("burst ext", 12'd8, u_dac.samp.size());
		wr(4'h5, 8'h00);
		$display("test burst done");
	endtask
	task automatic t_seq;
		logic [7:0] seg[8] = '{8'h00, 8'h00, 8'h01, 8'h00,
			8'h08, 8'h00, 8'h09, 8'h00};
		int i;
		wr(4'hA, 8'h00);
		for (i = 0; i < 8; i++)
			wr(4'hB, seg[i]);
		wr(4'hA, 8'h47);
		wr(4'hB, 8'h01);
		wr(4'h5, 8'h13);
		clr;
		take(8);
		for (i = 0; i < 7; i++)
			chk("seq next", nx(u_dac.samp[i]), u_dac.samp[i+1]);
		wr(4'h5, 8'h00);
		$display("test seq done");
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		chk("reset dac", 12'h000, dac_data);
		rst_n <= 1'b1;
		rd(4'hE);
		chk("status", 12'h0, rv[3:0]);
		rd(4'h3);
		chk("increment byte", 12'h0, rv);
		$display("test reset done");
		t_dds;
		t_synth;
		t_burst;
		t_seq;
		tally_and_finish;
	end
endmodule // tb

// ==== wag_checker.sv ====
/*
 * Port checker of the waveform address generator.
 * Assumes it is bound onto wag_engine and sees only its ports.
 */
`timescale 1ns/1ps
module wag_checker #(
	parameter DATA_W = 12
) (
	// clock and reset
	input wire              waveform_clock,
	input wire              rst_n,
	// host bus
	input wire [3:0]        host_addr,
	input wire [7:0]        host_wdata,
	input wire              host_wr,
	input wire              host_rd,
	input wire [7:0]        host_rdata,
	// trigger and dac side
	input wire              ext_trigger,
	input wire [DATA_W-1:0] dac_data,
	input wire              dac_sample_clock,
	input wire              sync_out,
	input wire              marker_out
);
	// ----------------------------------------------------------------
	// shadow of mode and run bits
	// ----------------------------------------------------------------
	reg [1:0] ctrl;
	always @(posedge waveform_clock or negedge rst_n) begin
		if (!rst_n)
			ctrl <= 2'h0;
		else if (host_wr && host_addr == 4'h5)
			ctrl <= host_wdata[1:0];
	end
	default clocking dcb @(posedge waveform_clock); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_low_one;
		$fell(dac_sample_clock) |=> dac_sample_clock;
	endproperty
	a_low_one: assert property (p_low_one)
		else $error("dac clock low longer than one cycle");
	property p_data_hold;
		!$fell(dac_sample_clock) |-> $stable(dac_data);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("dac data moved outside a tick");
	property p_flag_hold;
		!$fell(dac_sample_clock) |-> $stable({sync_out, marker_out});
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("sync or marker moved outside a tick");
	property p_rd_hold;
		!$past(host_rd) |-> $stable(host_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");
	property p_rd_spare;
		host_rd && host_addr == 4'hE |=> host_rdata[7:5] == 3'b000;
	endproperty
	a_rd_spare: assert property (p_rd_spare)
		else $error("status spare bits not zero");
	property p_mode_rd;
		host_rd && host_addr == 4'hE |=> host_rdata[3] == $past(ctrl[0]);
	endproperty
	a_mode_rd: assert property (p_mode_rd)
		else $error("status mode bit wrong");
	property p_idle_rd;
		host_rd && host_addr == 4'hE && !ctrl[1] && !$past(ctrl[1])
			|=> host_rdata[1:0] == 2'h0;
	endproperty
	a_idle_rd: assert property (p_idle_rd)
		else $error("status not idle while stopped");
	property p_idle_clk;
		$past(rst_n) && !ctrl[1] && !$past(ctrl[1]) && !$past(ctrl[1], 2)
			|-> dac_sample_clock;
	endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("tick while stopped");
endmodule // wag_checker

bind wag_engine wag_checker #(.DATA_W(DATA_W)) u_chk (
	.waveform_clock   (waveform_clock),
	.rst_n            (rst_n),
	.host_addr        (host_addr),
	.host_wdata       (host_wdata),
	.host_wr          (host_wr),
	.host_rd          (host_rd),
	.host_rdata       (host_rdata),
	.ext_trigger      (ext_trigger),
	.dac_data         (dac_data),
	.dac_sample_clock (dac_sample_clock),
	.sync_out         (sync_out),
	.marker_out       (marker_out)
);

// ==== wag_dac_model.sv ====
/*
 * Capture model of the waveform DAC: samples, sync flags, tick gaps.
 * Assumes a 20 ns waveform clock and settled data at the rising edge.
 */
`timescale 1ns/1ps
module wag_dac_model (
	// sample clock
	input wire        dac_sample_clock,
	// sample and flags
	input wire [11:0] dac_data,
	input wire        sync_out,
	input wire        marker_out
);
	logic [11:0] samp[$];
	logic        flag[$];
	logic        mark[$];
	int          gap[$];
	longint      last = 0;
	// ----------------------------------------------------------------
	// latch on rising sample clock
	// ----------------------------------------------------------------
	always @(posedge dac_sample_clock) begin
		samp.push_back(dac_data);
		flag.push_back(sync_out);
		mark.push_back(marker_out);
		gap.push_back(int'(($time - last) / 20));
		last = $time;
	end
endmodule // wag_dac_model

// ==== wag_defines.vh ====
/*
 * Port map, control fields, reset values and timing counts of the
 * waveform address generator.
 * Assumes inclusion by bare name from the engine source only.
 */
`ifndef WAG_DEFINES_VH
`define WAG_DEFINES_VH

// ----------------------------------------------------------------
// host port addresses (write side)
// ----------------------------------------------------------------
`define WAG_P_INC0    4'h0
`define WAG_P_INC3    4'h3
`define WAG_P_INC4    4'h4
`define WAG_P_CTRL    4'h5
`define WAG_P_DIV0    4'h6
`define WAG_P_DIV1    4'h7
`define WAG_P_DIV2    4'h8
`define WAG_P_DIV3    4'h9
`define WAG_P_TPTR    4'hA
`define WAG_P_TDATA   4'hB
`define WAG_P_RADR0   4'hC
`define WAG_P_RADR1   4'hD
`define WAG_P_RDAT0   4'hE
`define WAG_P_RDAT1   4'hF
// read side: these two ports show engine state
`define WAG_P_STATUS  4'hE
`define WAG_P_SEGIDX  4'hF

// ----------------------------------------------------------------
// control byte fields
// ----------------------------------------------------------------
`define WAG_C_MODE    0
`define WAG_C_RUN     1
`define WAG_C_EXTTRIG 2
`define WAG_C_BURST   3
`define WAG_C_SEQ     4
`define WAG_C_GATE    5
`define WAG_C_SQUARE  6
`define WAG_C_SWTRIG  7

// ----------------------------------------------------------------
// indirect table addresses
// ----------------------------------------------------------------
`define WAG_T_SEGTOP  8'h3F
`define WAG_T_BURST0  8'h40
`define WAG_T_BURST1  8'h41
`define WAG_T_BURST2  8'h42
`define WAG_T_LEN0    8'h43
`define WAG_T_LEN1    8'h44
`define WAG_T_MARK0   8'h45
`define WAG_T_MARK1   8'h46
`define WAG_T_SEGLAST 8'h47

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WAG_CTRL_RST  8'h00
`define WAG_DIV_RST   32'h00000001
`define WAG_LEN_RST   16'h0FFF
`define WAG_BURST_RST 20'h00001

// ----------------------------------------------------------------
// waveform geometry and timing
// ----------------------------------------------------------------
`define WAG_ACC_W       38
`define WAG_DDS_BITS    12
`define WAG_SQUARE_LAST 16'h0001
`define WAG_ARB_MINLEN  16'h0004
`define WAG_CLOCK_HZ    50000000
`define WAG_MAX_RATE_HZ 40000000
`define WAG_MIN_RATE_DHZ 1
`define WAG_DIV_MIN ((`WAG_CLOCK_HZ + `WAG_MAX_RATE_HZ - 1) / `WAG_MAX_RATE_HZ - 1)
`define WAG_DIV_MAX ((`WAG_CLOCK_HZ * 10) / `WAG_MIN_RATE_DHZ - 1)

`endif

// ==== wag_engine.v ====
/*
 * Waveform address generator: phase accumulator, clock-synthesis
 * address counter, sequencer, burst counter, trigger selection,
 * waveform RAM with host write path, sync and marker outputs.
 * Assumes one clock, a host on a plain 4-bit port bus with byte
 * data, and a DAC that latches on the rising dac_sample_clock.
 */
`timescale 1ns/1ps
`include "wag_defines.vh"

// How it works
// - mode bit picks accumulator (smooth shapes) or sequential counter playback.
// - clock-synthesis address steps by exactly one per sample tick.
// - clock-synthesis sample rate set by divider, clamped between 25 MHz and 0.1 Hz; accumulator mode runs at 25 MHz.
// - arbitrary length 4 to 65536; square fixed 2; pulse by length.
// - accumulator mode plays 4096 points per cycle.
// - host loads increment; accumulator adds it every clock.
// - top 12 accumulator bits address RAM; upper 4 lines zero.
// - accumulator is 38 bits wide.
// - new increment takes effect at once while running.
// - sample data stable before rising edge of DAC clock.
// - programmable divide-by-n sets clock-synthesis sample rate.
// - sequencer chains up to 16 segments.
// - 20-bit reloadable burst counter with trigger and gate control.
// - host reaches engine over 8-bit data, 16 ports.
// - all logic on the single waveform clock.
// - host writes waveform patterns into RAM.
// - sync and marker outputs generated with samples.
// - external square-wave trigger selectable as the trigger.
module wag_engine #(
	parameter ADDR_W  = 16,
	parameter DATA_W  = 12,
	parameter SEG_N   = 16,
	parameter [31:0] DIV_MAX = `WAG_DIV_MAX
) (
	// clock and reset
	input  wire              waveform_clock,
	input  wire              rst_n,
	// host port bus
	input  wire [3:0]        host_addr,
	input  wire [7:0]        host_wdata,
	input  wire              host_wr,
	input  wire              host_rd,
	output reg  [7:0]        host_rdata,
	// trigger and gate pin
	input  wire              ext_trigger,
	// dac side
	output reg  [DATA_W-1:0] dac_data,
	output reg               dac_sample_clock,
	output reg               sync_out,
	output reg               marker_out
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_WAIT = 2'b01;
localparam [1:0] ST_PLAY = 2'b10;
localparam [31:0] DIV_MIN = `WAG_DIV_MIN;
localparam [15:0] ARB_MIN_LAST = `WAG_ARB_MINLEN - 16'h0001;

// ----------------------------------------------------------------
// host registers
// ----------------------------------------------------------------
reg  [31:0]           inc_stage;
reg  [`WAG_ACC_W-1:0] phase_inc;
reg  [7:0]            ctrl;
reg  [31:0]           divisor;
reg  [7:0]            tptr;
reg  [19:0]           burst_load;
reg  [15:0]           arb_last;
reg  [15:0]           marker_addr;
reg  [3:0]            seg_last;
reg  [15:0]           seg_start [0:SEG_N-1];
reg  [15:0]           seg_end   [0:SEG_N-1];
reg  [ADDR_W-1:0]     ram_wr_addr;
reg  [7:0]            ram_lo;
reg  [DATA_W-1:0]     wave_ram  [0:(1<<ADDR_W)-1];
reg                   sw_trig;

// ----------------------------------------------------------------
// engine state
// ----------------------------------------------------------------
reg  [1:0]            state;
reg  [`WAG_ACC_W-1:0] acc;
reg  [ADDR_W-1:0]     cs_addr;
reg  [3:0]            seg_idx;
reg  [19:0]           burst_left;
reg  [31:0]           div_cnt;
reg                   trig_meta;
reg                   trig_sync;
reg                   trig_prev;

wire wr_table = host_wr && (host_addr == `WAG_P_TDATA);
wire mode_cs  = ctrl[`WAG_C_MODE];
wire playing  = (state == ST_PLAY);

// ----------------------------------------------------------------
// host writes
// ----------------------------------------------------------------
always @(posedge waveform_clock or negedge rst_n) begin
	if (!rst_n) begin
		inc_stage   <= 32'h00000000;
		phase_inc   <= {`WAG_ACC_W{1'b0}};
		ctrl        <= `WAG_CTRL_RST;
		divisor     <= `WAG_DIV_RST;
		tptr        <= 8'h00;
		burst_load  <= `WAG_BURST_RST;
		arb_last    <= `WAG_LEN_RST;
		marker_addr <= 16'h0000;
		seg_last    <= 4'h0;
		ram_wr_addr <= {ADDR_W{1'b0}};
		ram_lo      <= 8'h00;
		sw_trig     <= 1'b0;
	end else begin
		sw_trig <= 1'b0;
		if (host_wr) begin
			case (host_addr)
			`WAG_P_INC0: inc_stage[7:0]   <= host_wdata;
			4'h1:        inc_stage[15:8]  <= host_wdata;
			4'h2:        inc_stage[23:16] <= host_wdata;
			`WAG_P_INC3: inc_stage[31:24] <= host_wdata;
			// top byte commits all 38 bits at once
			`WAG_P_INC4: phase_inc <= {host_wdata[5:0], inc_stage};
			`WAG_P_CTRL: begin
				ctrl    <= {1'b0, host_wdata[6:0]};
				sw_trig <= host_wdata[`WAG_C_SWTRIG];
			end
			`WAG_P_DIV0: divisor[7:0]   <= host_wdata;
			`WAG_P_DIV1: divisor[15:8]  <= host_wdata;
			`WAG_P_DIV2: divisor[23:16] <= host_wdata;
			`WAG_P_DIV3: divisor[31:24] <= host_wdata;
			`WAG_P_TPTR: tptr <= host_wdata;
			`WAG_P_TDATA: begin
				tptr <= tptr + 8'h01;
				case (tptr)
				`WAG_T_BURST0: burst_load[7:0]   <= host_wdata;
				`WAG_T_BURST1: burst_load[15:8]  <= host_wdata;
				`WAG_T_BURST2: burst_load[19:16] <= host_wdata[3:0];
				`WAG_T_LEN0:   arb_last[7:0]     <= host_wdata;
				`WAG_T_LEN1:   arb_last[15:8]    <= host_wdata;
				`WAG_T_MARK0:  marker_addr[7:0]  <= host_wdata;
				`WAG_T_MARK1:  marker_addr[15:8] <= host_wdata;
				`WAG_T_SEGLAST: seg_last <= host_wdata[3:0];
				default: ;
				endcase
			end
			`WAG_P_RADR0: ram_wr_addr[7:0]  <= host_wdata;
			`WAG_P_RADR1: ram_wr_addr[15:8] <= host_wdata;
			`WAG_P_RDAT0: ram_lo <= host_wdata;
			`WAG_P_RDAT1: ram_wr_addr <= ram_wr_addr + 16'h0001;
			default: ;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// segment table, one entry per generate pass
// ----------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < SEG_N; gi = gi + 1) begin : g_seg
		wire hit = wr_table && (tptr <= `WAG_T_SEGTOP) &&
			(tptr[5:2] == gi);
		always @(posedge waveform_clock or negedge rst_n) begin
			if (!rst_n) begin
				seg_start[gi] <= 16'h0000;
				seg_end[gi]   <= 16'h0000;
			end else if (hit) begin
				case (tptr[1:0])
				2'd0: seg_start[gi][7:0]  <= host_wdata;
				2'd1: seg_start[gi][15:8] <= host_wdata;
				2'd2: seg_end[gi][7:0]    <= host_wdata;
				default: seg_end[gi][15:8] <= host_wdata;
				endcase
			end
		end
	end
endgenerate

// ----------------------------------------------------------------
// trigger pin synchroniser and selection
// ----------------------------------------------------------------
always @(posedge waveform_clock or negedge rst_n) begin
	if (!rst_n) begin
		trig_meta <= 1'b0;
		trig_sync <= 1'b0;
		trig_prev <= 1'b0;
	end else begin
		trig_meta <= ext_trigger;
		trig_sync <= trig_meta;
		trig_prev <= trig_sync;
	end
end

wire ext_rise = trig_sync && !trig_prev;
wire trig_evt = ctrl[`WAG_C_EXTTRIG] ? ext_rise : sw_trig;
// gate holds playback while the pin is low
wire gate_ok  = !ctrl[`WAG_C_GATE] || trig_sync;

// ----------------------------------------------------------------
// sample tick divider
// ----------------------------------------------------------------
reg  [31:0] div_eff;
always @* begin
	if (!mode_cs)
		div_eff = DIV_MIN;
	else if (divisor < DIV_MIN)
		div_eff = DIV_MIN;
	else if (divisor > DIV_MAX)
		div_eff = DIV_MAX;
	else
		div_eff = divisor;
end

wire tick = playing && (div_cnt == 32'h00000000);

always @(posedge waveform_clock or negedge rst_n) begin
	if (!rst_n)
		div_cnt <= 32'h00000000;
	else if (!playing || tick)
		div_cnt <= div_eff;
	else
		div_cnt <= div_cnt - 32'h00000001;
end

// ----------------------------------------------------------------
// address generation
// ----------------------------------------------------------------
wire [`WAG_ACC_W:0] acc_sum = {1'b0, acc} + {1'b0, phase_inc};
wire dds_step = playing && !mode_cs && gate_ok;
wire cs_step  = playing && mode_cs && tick && gate_ok;
wire seq_on   = ctrl[`WAG_C_SEQ];

reg  [15:0] cur_start;
reg  [15:0] cur_end;
always @* begin
	if (seq_on) begin
		cur_start = seg_start[seg_idx];
		cur_end   = seg_end[seg_idx];
	end else if (ctrl[`WAG_C_SQUARE]) begin
		cur_start = 16'h0000;
		cur_end   = `WAG_SQUARE_LAST;
	end else begin
		cur_start = 16'h0000;
		cur_end   = (arb_last < ARB_MIN_LAST) ? ARB_MIN_LAST : arb_last;
	end
end

wire seg_done  = cs_step && (cs_addr >= cur_end);
wire last_seg  = !seq_on || (seg_idx == seg_last);
wire cycle_end = mode_cs ? (seg_done && last_seg)
	: (dds_step && acc_sum[`WAG_ACC_W]);
wire burst_stop = ctrl[`WAG_C_BURST] && cycle_end &&
	(burst_left <= 20'h00001);

wire [ADDR_W-1:0] rd_addr = mode_cs ? cs_addr
	: {{(ADDR_W-`WAG_DDS_BITS){1'b0}},
	acc[`WAG_ACC_W-1 -: `WAG_DDS_BITS]};

always @(posedge waveform_clock or negedge rst_n) begin
	if (!rst_n) begin
		acc     <= {`WAG_ACC_W{1'b0}};
		cs_addr <= {ADDR_W{1'b0}};
		seg_idx <= 4'h0;
	end else if (!playing || burst_stop) begin
		acc     <= {`WAG_ACC_W{1'b0}};
		cs_addr <= seq_on ? seg_start[0] : 16'h0000;
		seg_idx <= 4'h0;
	end else begin
		if (dds_step)
			acc <= acc_sum[`WAG_ACC_W-1:0];
		if (seg_done) begin
			if (seq_on) begin
				// next segment, wrapping after the last one
				seg_idx <= last_seg ? 4'h0 : seg_idx + 4'h1;
				cs_addr <= last_seg ? seg_start[0]
					: seg_start[seg_idx + 4'h1];
			end else begin
				cs_addr <= cur_start;
			end
		end else if (cs_step) begin
			cs_addr <= cs_addr + 16'h0001;
		end
	end
end

// ----------------------------------------------------------------
// run, trigger and burst control
// ----------------------------------------------------------------
always @(posedge waveform_clock or negedge rst_n) begin
	if (!rst_n) begin
		state      <= ST_IDLE;
		burst_left <= 20'h00000;
	end else begin
		case (state)
		ST_IDLE: begin
			if (ctrl[`WAG_C_RUN])
				state <= ctrl[`WAG_C_BURST] ? ST_WAIT : ST_PLAY;
		end
		ST_WAIT: begin
			if (!ctrl[`WAG_C_RUN]) begin
				state <= ST_IDLE;
			end else if (trig_evt) begin
				burst_left <= burst_load;
				state      <= ST_PLAY;
			end
		end
		ST_PLAY: begin
			if (!ctrl[`WAG_C_RUN])
				state <= ST_IDLE;
			else if (burst_stop)
				state <= ST_WAIT;
			else if (ctrl[`WAG_C_BURST] && cycle_end)
				burst_left <= burst_left - 20'h00001;
		end
		default: state <= ST_IDLE;
		endcase
	end
end

// ----------------------------------------------------------------
// waveform RAM: host write port, sample read port
// ----------------------------------------------------------------
always @(posedge waveform_clock) begin
	if (host_wr && (host_addr == `WAG_P_RDAT1))
		wave_ram[ram_wr_addr] <= {host_wdata[DATA_W-9:0], ram_lo};
end

// ----------------------------------------------------------------
// sample, dac clock, sync and marker
// ----------------------------------------------------------------
always @(posedge waveform_clock or negedge rst_n) begin
	if (!rst_n) begin
		dac_data         <= {DATA_W{1'b0}};
		dac_sample_clock <= 1'b0;
		sync_out         <= 1'b0;
		marker_out       <= 1'b0;
	end else if (tick) begin
		// data changes with the clock low; it rises one cycle later
		dac_data         <= wave_ram[rd_addr];
		dac_sample_clock <= 1'b0;
		sync_out         <= (rd_addr == cur_start) &&
			(!seq_on || seg_idx == 4'h0);
		marker_out       <= (rd_addr == marker_addr);
	end else begin
		dac_sample_clock <= 1'b1;
	end
end

// ----------------------------------------------------------------
// host reads
// ----------------------------------------------------------------
always @(posedge waveform_clock or negedge rst_n) begin
	if (!rst_n) begin
		host_rdata <= 8'h00;
	end else if (host_rd) begin
		case (host_addr)
		`WAG_P_INC0:   host_rdata <= inc_stage[7:0];
		4'h1:          host_rdata <= inc_stage[15:8];
		4'h2:          host_rdata <= inc_stage[23:16];
		`WAG_P_INC3:   host_rdata <= inc_stage[31:24];
		`WAG_P_INC4:   host_rdata <= {2'b00, phase_inc[37:32]};
		`WAG_P_CTRL:   host_rdata <= ctrl;
		`WAG_P_DIV0:   host_rdata <= divisor[7:0];
		`WAG_P_DIV1:   host_rdata <= divisor[15:8];
		`WAG_P_DIV2:   host_rdata <= divisor[23:16];
		`WAG_P_DIV3:   host_rdata <= divisor[31:24];
		`WAG_P_TPTR:   host_rdata <= tptr;
		`WAG_P_RADR0:  host_rdata <= ram_wr_addr[7:0];
		`WAG_P_RADR1:  host_rdata <= ram_wr_addr[15:8];
		`WAG_P_STATUS: host_rdata <= {3'b000, burst_left == 20'h00000,
			mode_cs, trig_sync, state};
		`WAG_P_SEGIDX: host_rdata <= {4'h0, seg_idx};
		default:       host_rdata <= 8'h00;
		endcase
	end
end

endmodule // wag_engine
